// >>> aps_master_model.sv
module aps_master_model (
  // Request from the bench
  input wire logic go,
  // Link pins
  input wire logic dataIn,
  output logic linkClk,
  // Captured frame
  output logic [30:0] frameSeen,
  output logic busy
);
  timeunit 1ns;
  timeprecision 100ps;

  // --------------------------------
  // Idle state
  // --------------------------------
  // Clock stands high between frames, as a real master leaves it
  initial begin
    linkClk = 1'b1;
    busy = 1'b0;
    frameSeen = 31'h00000000;
  end

  // --------------------------------
  // One read cycle
  // --------------------------------
  // Long first low phase, then 31 periods of 30 ns; data sampled on falling edges
  always @(posedge go) begin
    busy = 1'b1;
    #7 linkClk = 1'b0;
    #30; // First rise well after the fall, so the slave sees the request
    for (int k = 0; k < 31; k++) begin
      linkClk = 1'b1;
      #15 linkClk = 1'b0;
      frameSeen = {frameSeen[29:0], dataIn};
      #15;
    end
    linkClk = 1'b1;
    busy = 1'b0;
  end
endmodule

// >>> aps_pkg.sv
`include "aps_serial_map.svh"

package aps_pkg;
  typedef logic [`APS_POS_W-1:0] aps_pos_t;
  typedef logic [3:0] aps_addr_t;
  typedef logic [`APS_FRAME_W-1:0] aps_frame_t;
  typedef logic [`APS_CRC_W-1:0] aps_crc_t;
  typedef enum logic {APS_SSI, APS_BISS} aps_mode_t;
endpackage

// >>> aps_serial_map.svh
// Behaviour
// - The link is a point-to-point slave; data moves only on master clock edges.
// - SSI with test option: flag low when signals normal, high on critical fault.
// - SSI without test option: no error bit follows the position data.
// - SSI requests spaced over bits times period plus 26 us; monoflop lasts 25 us.
// - BiSS-C slave shifts its frame out only under the master clock.
// - BiSS-C: data held low one clock as acknowledge after clocking starts.
// - After acknowledge, one start bit of 1, then one bit of 0.
// - BiSS-C layout: position above bit 7, error 7, warning 6 high, CRC 0-5.
// - BiSS-C with test option: error bit high when normal, low on fault.
// - BiSS-C without test option: error bit always high.
// - Six-bit CRC x^6+x+1 over position, error, warning; sent inverted, MSB first.
// - Start bit and its zero follower are kept out of the CRC.
// - BiSS-C: 25 us timeout between start request cycles before a new frame.
// - Setup mode: clock pair is receive line, data pair is transmit line.
// - After reset the block starts in position output mode, not setup mode.
`ifndef APS_SERIAL_MAP_SVH
`define APS_SERIAL_MAP_SVH

// ----------------------------------------
// Frame layout
// ----------------------------------------
`define APS_POS_W 20
`define APS_FRAME_W 31
`define APS_IDX_W 5
`define APS_IDX_DONE 5'h1F
`define APS_B_ACK 30
`define APS_B_START 29
`define APS_B_ZERO 28
`define APS_B_POS_LSB 8
`define APS_B_ERR 7
`define APS_B_WARN 6
`define APS_S_POS_LSB 11
`define APS_S_ERR 10
`define APS_CRC_W 6
`define APS_CRC_IN_W 22
`define APS_CRC_POLY 6'h03

// ----------------------------------------
// Registers
// ----------------------------------------
`define APS_REG_CTRL 4'h0
`define APS_REG_STATUS 4'h4
`define APS_REG_FRAMES 4'h8
`define APS_REG_POS 4'hC
`define APS_CTRL_W 4
`define APS_CTRL_RST 4'h8
`define APS_CTRL_BISS 0
`define APS_CTRL_BITOPT 1
`define APS_CTRL_SETUP 2
`define APS_CTRL_TX 3

// ----------------------------------------
// Timing
// ----------------------------------------
`define APS_CLK_NS 4
`define APS_MONO_NS 25000
`define APS_IDLE_W 16
`define APS_CNT_W 16

`endif

// >>> aps_serial_slave.sv
`include "aps_serial_map.svh"

module aps_serial_slave #(
  parameter int MONO_CYCLES = (`APS_MONO_NS + `APS_CLK_NS - 1) / `APS_CLK_NS
) (
  // System clock and reset
  input wire logic clk,
  input wire logic reset,
  // Position source
  input wire aps_pkg::aps_pos_t positionIn,
  input wire logic faultIn,
  // Register port
  input wire aps_pkg::aps_addr_t regAddr,
  input wire logic [31:0] regWrData,
  input wire logic regWr,
  input wire logic regRd,
  output logic [31:0] regRdData,
  // Serial link
  input wire logic linkClk,
  output logic serialOut
);
  import aps_pkg::*;

  localparam logic [`APS_IDLE_W-1:0] MONO_LIM = `APS_IDLE_W'(MONO_CYCLES - 1);

  // ----------------------------------------
  // Declarations
  // ----------------------------------------
  logic [`APS_CTRL_W-1:0] ctrl_reg;
  logic [31:0] regRdData_reg;
  logic [31:0] regRdData_next;
  logic clkMeta_reg;
  logic clkSync_reg;
  logic clkPrev_reg;
  logic [`APS_IDLE_W-1:0] idleCnt_reg;
  logic frameIdle_reg;
  logic timeoutHit;
  logic frameStart;
  aps_frame_t frame_reg;
  aps_frame_t frame_next;
  aps_pos_t posLatch_reg;
  logic [`APS_CNT_W-1:0] frames_reg;
  logic dataMeta_reg;
  logic dataSync_reg;
  logic serialOut_reg;
  logic linkClear;
  logic [`APS_IDX_W-1:0] bitIdx_reg;
  logic [`APS_IDX_W-1:0] bitPos;
  logic linkBit_reg;
  aps_mode_t mode;
  logic bitFitted;
  logic setupOn;
  logic errSsi;
  logic errBiss;
  logic [`APS_CRC_IN_W-1:0] crcIn;
  aps_crc_t crcChain [`APS_CRC_IN_W+1];
  aps_crc_t crcOut;

  assign mode = ctrl_reg[`APS_CTRL_BISS] ? APS_BISS : APS_SSI;
  assign bitFitted = ctrl_reg[`APS_CTRL_BITOPT];
  assign setupOn = ctrl_reg[`APS_CTRL_SETUP];

  // ----------------------------------------
  // Register port
  // ----------------------------------------

  // Control register; comes up in position output mode
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      ctrl_reg <= `APS_CTRL_RST;
    end else if (regWr && regAddr == `APS_REG_CTRL) begin
      ctrl_reg <= regWrData[`APS_CTRL_W-1:0];
    end
  end

  // Read mux; unmapped offsets answer zero
  always_comb begin
    regRdData_next = 32'h0;
    case (regAddr)
      `APS_REG_CTRL: begin
        regRdData_next[`APS_CTRL_W-1:0] = ctrl_reg;
      end
      `APS_REG_STATUS: begin
        regRdData_next[0] = !frameIdle_reg;
        regRdData_next[1] = clkSync_reg;
        regRdData_next[2] = serialOut_reg;
      end
      `APS_REG_FRAMES: begin
        regRdData_next[`APS_CNT_W-1:0] = frames_reg;
      end
      `APS_REG_POS: begin
        regRdData_next[`APS_POS_W-1:0] = posLatch_reg;
      end
      default: begin
        regRdData_next = 32'h0;
      end
    endcase
  end

  // Read data valid only in the cycle after the strobe
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      regRdData_reg <= 32'h0;
    end else if (regRd) begin
      regRdData_reg <= regRdData_next;
    end else begin
      regRdData_reg <= 32'h0;
    end
  end

  assign regRdData = regRdData_reg;

  // ----------------------------------------
  // Master clock watch
  // ----------------------------------------

  // Link clock level seen as data, two stages before use
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      clkMeta_reg <= 1'b1;
      clkSync_reg <= 1'b1;
      clkPrev_reg <= 1'b1;
    end else begin
      clkMeta_reg <= linkClk;
      clkSync_reg <= clkMeta_reg;
      clkPrev_reg <= clkSync_reg;
    end
  end

  // Quiet time since the last master clock change
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      idleCnt_reg <= MONO_LIM;
    end else if (clkSync_reg != clkPrev_reg) begin
      idleCnt_reg <= '0;
    end else if (!timeoutHit) begin
      idleCnt_reg <= idleCnt_reg + 1'b1;
    end
  end

  assign timeoutHit = (idleCnt_reg == MONO_LIM);
  // A frame opens on the first low level of the idle-high master clock
  assign frameStart = frameIdle_reg && !clkSync_reg && !setupOn;

  // Monoflop: frame ends after the quiet interval with clock high
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      frameIdle_reg <= 1'b1;
    end else if (frameStart) begin
      frameIdle_reg <= 1'b0;
    end else if (timeoutHit && clkSync_reg) begin
      frameIdle_reg <= 1'b1;
    end
  end

  // Frames started, readable for software
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      frames_reg <= '0;
    end else if (frameStart) begin
      frames_reg <= frames_reg + 1'b1;
    end
  end

  // ----------------------------------------
  // Frame build
  // ----------------------------------------

  // Error flag polarity differs between the two framings
  assign errSsi = bitFitted ? faultIn : 1'b0;
  assign errBiss = bitFitted ? !faultIn : 1'b1;

  // CRC covers position, error and warning only
  assign crcIn = {positionIn, errBiss, 1'b1};
  assign crcChain[0] = '0;

  // One shift-and-divide step per input bit, MSB first
  genvar gi;
  generate
    for (gi = 0; gi < `APS_CRC_IN_W; gi = gi + 1) begin : g_crc
      logic fb;
      assign fb = crcChain[gi][`APS_CRC_W-1] ^ crcIn[`APS_CRC_IN_W-1-gi];
      assign crcChain[gi+1] = {crcChain[gi][`APS_CRC_W-2:0], 1'b0}
                              ^ (fb ? `APS_CRC_POLY : 6'h00);
    end
  endgenerate

  assign crcOut = ~crcChain[`APS_CRC_IN_W];

  // Frame word, MSB leaves first; BiSS bit numbers match line positions
  always_comb begin
    frame_next = '0;
    if (mode == APS_BISS) begin
      frame_next[`APS_B_ACK] = 1'b0;
      frame_next[`APS_B_START] = 1'b1;
      frame_next[`APS_B_ZERO] = 1'b0;
      frame_next[`APS_B_ACK-3:`APS_B_POS_LSB] = positionIn;
      frame_next[`APS_B_ERR] = errBiss;
      frame_next[`APS_B_WARN] = 1'b1;
      frame_next[`APS_CRC_W-1:0] = crcOut;
    end else begin
      frame_next[`APS_FRAME_W-1:`APS_S_POS_LSB] = positionIn;
      frame_next[`APS_S_ERR] = errSsi;
    end
  end

  // Track the source only while idle; frozen for the whole frame
  // so the link side reads a quiet word without a crossing stage
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      frame_reg <= '0;
      posLatch_reg <= '0;
    end else if (frameIdle_reg && !frameStart) begin
      frame_reg <= frame_next;
      posLatch_reg <= positionIn;
    end
  end

  // ----------------------------------------
  // Link domain
  // ----------------------------------------

  // Held clear while idle; the master clock may stand still here
  assign linkClear = reset || frameIdle_reg;
  assign bitPos = `APS_IDX_W'(`APS_FRAME_W - 1) - bitIdx_reg;

  // Bit counter, one step per master rising edge
  always_ff @(posedge linkClk or posedge linkClear) begin
    if (linkClear) begin
      bitIdx_reg <= '0;
    end else if (bitIdx_reg != `APS_IDX_DONE) begin
      bitIdx_reg <= bitIdx_reg + 1'b1;
    end
  end

  // Data bit; low after the last bit until the monoflop expires
  always_ff @(posedge linkClk or posedge linkClear) begin
    if (linkClear) begin
      linkBit_reg <= 1'b1;
    end else if (bitIdx_reg != `APS_IDX_DONE) begin
      linkBit_reg <= frame_reg[bitPos];
    end else begin
      linkBit_reg <= 1'b0;
    end
  end

  // ----------------------------------------
  // Pin driver
  // ----------------------------------------

  // Link bit back into the system domain; adds about 12 ns,
  // well inside the bit update delay the master allows
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      dataMeta_reg <= 1'b1;
      dataSync_reg <= 1'b1;
    end else begin
      dataMeta_reg <= linkBit_reg;
      dataSync_reg <= dataMeta_reg;
    end
  end

  // Setup mode hands the data pair to the transmit bit
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      serialOut_reg <= 1'b1;
    end else if (setupOn) begin
      serialOut_reg <= ctrl_reg[`APS_CTRL_TX];
    end else begin
      serialOut_reg <= dataSync_reg;
    end
  end

  assign serialOut = serialOut_reg;

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);

  chk_setup_off_reset:
    assert property ($past(reset) |-> !setupOn && mode == APS_SSI)
    else $error("setup mode active after reset");

  chk_idle_line_high:
    assert property ((frameIdle_reg && !setupOn)[*4] |-> serialOut)
    else $error("data line not high while idle");

  chk_setup_tx_path:
    assert property (setupOn && $past(setupOn) |-> serialOut == $past(ctrl_reg[`APS_CTRL_TX]))
    else $error("setup transmit bit not on data line");

  chk_frame_frozen:
    assert property (!frameIdle_reg && $past(!frameIdle_reg) |-> $stable(frame_reg))
    else $error("frame word changed during a frame");

  chk_biss_header:
    assert property (frameIdle_reg && !frameStart && mode == APS_BISS |=>
      !frame_reg[`APS_B_ACK] && frame_reg[`APS_B_START] && !frame_reg[`APS_B_ZERO])
    else $error("bad acknowledge or start bits");

  chk_biss_err_bit:
    assert property (frameIdle_reg && !frameStart && mode == APS_BISS |=>
      frame_reg[`APS_B_ERR] == ($past(bitFitted) ? !$past(faultIn) : 1'b1))
    else $error("bad error bit in bidirectional frame");

  chk_ssi_err_bit:
    assert property (frameIdle_reg && !frameStart && mode == APS_SSI |=>
      frame_reg[`APS_S_ERR] == ($past(bitFitted) && $past(faultIn)))
    else $error("bad error bit in SSI frame");

  chk_frame_timeout:
    assert property ($rose(frameIdle_reg) |-> $past(idleCnt_reg) == MONO_LIM)
    else $error("frame closed before the quiet interval");

  chk_frame_open:
    assert property (frameStart |=> !frameIdle_reg ##1 !frameIdle_reg)
    else $error("frame did not open on master clock");

  chk_ssi_pos_field:
    assert property (frameIdle_reg && !frameStart && mode == APS_SSI |=>
      frame_reg[`APS_FRAME_W-1:`APS_S_POS_LSB] == $past(positionIn))
    else $error("position field wrong in SSI frame");

  chk_ssi_tail_zero:
    assert property (frameIdle_reg && !frameStart && mode == APS_SSI && !bitFitted |=>
      frame_reg[`APS_S_ERR:0] == '0)
    else $error("extra bits after SSI position");

  chk_biss_payload:
    assert property (frameIdle_reg && !frameStart && mode == APS_BISS |=>
      frame_reg[`APS_B_ACK-3:`APS_B_POS_LSB] == $past(positionIn)
      && frame_reg[`APS_B_WARN])
    else $error("bad position or warning field in bidirectional frame");

  chk_link_held_idle:
    assert property (frameIdle_reg |-> bitIdx_reg == '0)
    else $error("link bit counter moved outside a frame");

  cov_biss_frame: cover property (mode == APS_BISS && $fell(frameIdle_reg));
  cov_fault_frame: cover property (bitFitted && faultIn && $fell(frameIdle_reg));
  cov_ssi_frame: cover property (mode == APS_SSI && $fell(frameIdle_reg));
  cov_setup_tx: cover property (setupOn && $changed(serialOut));

endmodule

// >>> aps_tb.sv
module tb;
  timeunit 1ns;
  timeprecision 100ps;
  import aps_pkg::*;

  localparam int MONO = 100;
  logic clk = 1'b0;
  logic reset = 1'b1;
  aps_pos_t positionIn = 20'h00000;
  logic faultIn = 1'b0;
  aps_addr_t regAddr = 4'h0;
  logic [31:0] regWrData = 32'h00000000;
  logic regWr = 1'b0;
  logic regRd = 1'b0;
  logic [31:0] regRdData;
  logic linkClk;
  logic serialOut;
  logic go = 1'b0;
  logic [30:0] frameSeen;
  logic busy;
  logic [31:0] rd;
  logic [30:0] exp;
  logic [30:0] got;
  logic errBit;
  int mismatches = 0;
  int checked = 0;
  int n;
  logic [3:0] ctrlTab [6] = '{4'h8, 4'hA, 4'hA, 4'hB, 4'hB, 4'h9};
  logic faultTab [6] = '{1'b1, 1'b1, 1'b0, 1'b0, 1'b1, 1'b1};
  aps_pos_t posTab [6] = '{20'hFFFFF, 20'h00001, 20'hA5C3E, 20'h80000, 20'h5A3C1, 20'h00000};

  // --------------------------------
  // Clock, design and far side
  // --------------------------------
  always #2 clk = ~clk;

  aps_serial_slave #(.MONO_CYCLES(MONO)) DUT (.clk(clk), .reset(reset),
    .positionIn(positionIn), .faultIn(faultIn), .regAddr(regAddr), .regWrData(regWrData),
    .regWr(regWr), .regRd(regRd), .regRdData(regRdData), .linkClk(linkClk),
    .serialOut(serialOut));

  aps_master_model master (.go(go), .dataIn(serialOut), .linkClk(linkClk),
    .frameSeen(frameSeen), .busy(busy));

  // --------------------------------
  // Tasks
  // --------------------------------
  task automatic stop_test();
    if (mismatches == 0 && checked > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  task automatic chk(string name, logic [31:0] seen, logic [31:0] want);
    checked++;
    if (seen !== want) begin
      mismatches++;
      $display("unexpected %s expected %h seen %h", name, want, seen);
    end
  endtask

  task automatic wrReg(aps_addr_t a, logic [31:0] d);
    @(posedge clk);
    regAddr <= a;
    regWrData <= d;
    regWr <= 1'b1;
    @(posedge clk);
    regWr <= 1'b0;
  endtask

  // Read data stands only in the cycle after the strobe
  task automatic rdReg(aps_addr_t a, output logic [31:0] d);
    @(posedge clk);
    regAddr <= a;
    regRd <= 1'b1;
    @(posedge clk);
    regRd <= 1'b0;
    #1 d = regRdData;
  endtask

  // Inverted CRC x^6+x+1, seed zero, MSB first
  function automatic logic [5:0] crcOf(logic [21:0] v);
    logic [5:0] c;
    logic fb;
    c = 6'h00;
    for (int i = 21; i >= 0; i--) begin
      fb = c[5] ^ v[i];
      c = {c[4:0], 1'b0} ^ (fb ? 6'h03 : 6'h00);
    end
    return ~c;
  endfunction

  // One read; then line low until the quiet interval ends, then idle high
  task automatic runFrame(output logic [30:0] f, output int q, input logic after);
    @(posedge clk);
    go <= 1'b1;
    @(posedge clk);
    go <= 1'b0;
    q = 0;
    while (busy !== 1'b0 && q < 2000) begin
      @(posedge clk);
      q++;
    end
    f = frameSeen;
    repeat (5) @(posedge clk);
    chk("lineAfterFrame", {31'h0, serialOut}, {31'h0, after});
    q = 5;
    while (serialOut !== 1'b1 && q < MONO + 50) begin
      @(posedge clk);
      q++;
    end
  endtask

  // --------------------------------
  // Tests
  // --------------------------------
  initial begin
    repeat (3) @(posedge clk);
    reset <= 1'b0;
    rdReg(4'h0, rd);
    chk("ctrlReset", rd, 32'h8);
    @(posedge clk);
    #1 chk("rdDataAfter", regRdData, 32'h0);
    wrReg(4'h2, 32'h7);
    rdReg(4'h2, rd);
    chk("unmapped", rd, 32'h0);
    rdReg(4'h0, rd);
    chk("ctrlKept", rd, 32'h8);
    // Every framing and test-option case; with fault and without only where the option is fitted
    for (int i = 0; i < 6; i++) begin
      wrReg(4'h0, {28'h0, ctrlTab[i]});
      positionIn <= posTab[i];
      faultIn <= faultTab[i];
      repeat (4) @(posedge clk);
      errBit = ctrlTab[i][0] ? (ctrlTab[i][1] ? ~faultTab[i] : 1'b1)
                             : (ctrlTab[i][1] & faultTab[i]);
      exp = ctrlTab[i][0] ? {3'b010, posTab[i], errBit, 1'b1, crcOf({posTab[i], errBit, 1'b1})}
                          : {posTab[i], errBit, 10'h000};
      runFrame(got, n, 1'b0);
      chk("frame", {1'b0, got}, {1'b0, exp});
      chk("monoflop", {31'h0, n >= MONO && n <= MONO + 10}, 32'h1);
      rdReg(4'hC, rd);
      chk("posLatched", rd, {12'h000, posTab[i]});
      rdReg(4'h8, rd);
      chk("frameCount", rd, i + 1);
    end
    // Setup mode: data line follows the TX bit, frames refused
    wrReg(4'h0, 32'hC);
    runFrame(got, n, 1'b1);
    chk("setupFrame", {1'b0, got}, 32'h7FFFFFFF);
    wrReg(4'h0, 32'h4);
    repeat (3) @(posedge clk);
    #1 chk("setupTx", {31'h0, serialOut}, 32'h0);
    rdReg(4'h4, rd);
    chk("setupRx", {29'h0, rd[2:0]}, 32'h2);
    rdReg(4'h8, rd);
    chk("noSetupFrame", rd, 32'h6);
    wrReg(4'h0, 32'h8);
    repeat (3) @(posedge clk);
    #1 chk("idleLine", {31'h0, serialOut}, 32'h1);
    stop_test();
  end

  // Whole run is some 10 us; allow twenty times that
  initial begin
    #200000;
    mismatches++;
    stop_test();
  end
endmodule
